/* File: src/osc_switch.sv */
/*
 * Oscillator control: tunable DIGITAL_TUNED_OSC settings, reference clock divider with
 * fractional trim and a protected clock switch sequencer behind an Avalon-MM slave.
 * Assumes oscillator readiness, PLL lock and new-clock ticks arrive synchronous to CLOCK.
 */
// The Avalon-MM register port and the register offsets were chosen for this implementation.
// Behaviour
// - DIGITAL_TUNED_OSC trim is signed six bits, zero is centre, steps of about 0.15 percent.
// - At 16 or 32 MHz settings trim steps grow, spanning about 9.2 percent.
// - Sleep-keep bit one keeps DIGITAL_TUNED_OSC running in sleep, zero stops it.
// - Frequency select 0..7 gives 1..8 MHz, 1110 16 MHz, 1111 32 MHz; resets 0111.
// - Divider value is reference half-period in source cycles; reset one divides by two.
// - Divider value zero passes the source clock through.
// - Nine-bit trim adds n/512 source cycle to each half-period.
// - Switching and fail-safe active only when configuration bit is zero; clock-fail flag still sets on CLOCK_FAIL_EVENT when it is one.
// - Switching disabled: next-source ignored, current-source shows boot selection.
// - Switching disabled: request bit ignores writes and reads zero.
// - High unlock is 78h then 9Ah, next-source write follows at once.
// - Low unlock is 46h then 57h, request set follows at once.
// - Request with next equal to current clears request and aborts.
// - Valid switch start clears PLL lock status and clock-fail flag.
// - New source enabled; crystal waits start-up timer, PLL waits for lock.
// - After 10 new-clock cycles switch, clear request, copy next into current.
// - Old source stopped, except LOW_POWER_RC_OSC for watchdog/monitor and secondary kept alive.
// - Current-source 001 is fast RC with PLL, 011 is primary with PLL.
`timescale 1ns/1ns
`include "osc_switch_cfg.svh"

module osc_switch
(
   // Clock and reset
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   // Avalon-MM slave
   input  wire logic [3:0]  ADDRESS,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] WRITEDATA,
   input  wire logic [3:0]  BYTEENABLE,
   output logic      [31:0] READDATA,
   output logic             WAITREQUEST,
   // Configuration straps
   input  wire logic        SWITCH_MONITOR_CFG_BIT,
   input  wire logic [2:0]  BOOT_SOURCE_CFG,
   // Oscillator status
   input  wire logic [6:0]  OSC_READY,
   input  wire logic        STARTUP_TIMER_DONE,
   input  wire logic        PLL_LOCKED,
   input  wire logic        NEW_CLK_TICK,
   input  wire logic        CLOCK_FAIL_EVENT,
   input  wire logic        SLEEP_MODE,
   input  wire logic        WDT_OR_MONITOR_ON,
   input  wire logic        SECONDARY_KEEPALIVE,
   input  wire logic        REF_SRC_CLK,
   input  wire logic        REF_SRC_TICK,
   // Oscillator controls
   output logic      [6:0]  OSC_ENABLE,
   output logic      [2:0]  SYS_CLK_SELECT,
   output logic             DCO_RUN,
   output logic      [3:0]  DCO_FREQ_SELECT,
   output logic      [5:0]  DCO_TRIM_FIELD,
   output logic             DCO_WIDE_STEP,
   output logic             REF_CLK_OUT
);

   osc_switch_pkg::osc_state_t s_ff;
   osc_switch_pkg::osc_state_t nxt_s;

   logic        switch_enabled;
   logic        wr;
   logic        rd;
   logic        is_pll_src;
   logic        is_xtal_src;
   logic [15:0] half_full;
   logic [31:0] rmux;

   assign switch_enabled = ~SWITCH_MONITOR_CFG_BIT;
   assign wr = WRITE & s_ff.bus_ack;
   assign rd = READ & ~WRITE & ~s_ff.bus_ack;
   assign is_pll_src = (s_ff.next_source_sel == `SRC_FRC_PLL) ||
                       (s_ff.next_source_sel == `SRC_PRI_PLL);
   assign is_xtal_src = (s_ff.next_source_sel == `SRC_PRI) ||
                        (s_ff.next_source_sel == `SRC_PRI_PLL) ||
                        (s_ff.next_source_sel == `SRC_SEC);
   assign half_full = {1'b0, s_ff.ref_div};

   always_comb
   begin
      rmux = 32'h0;
      unique case (ADDRESS)
         `ADR_OSC_CONTROL:
         begin
            rmux[`CUR_SRC_LSB +: 3] = s_ff.current_source_sel;
            rmux[`NXT_SRC_LSB +: 3] = s_ff.next_source_sel;
            rmux[`LOCK_BIT] = s_ff.pll_lock;
            rmux[`FAIL_BIT] = s_ff.clock_fail_flag;
            rmux[`REQ_BIT] = s_ff.switch_request & switch_enabled;
         end
         `ADR_DCO_TRIM:     rmux[5:0] = s_ff.dco_trim_field;
         `ADR_DCO_CONTROL:
         begin
            rmux[13] = s_ff.dco_sleep_keep;
            rmux[11:8] = s_ff.dco_freq_select;
         end
         `ADR_REF_DIVIDER:  rmux[14:0] = s_ff.ref_div;
         `ADR_REF_FRACTION: rmux[15:7] = s_ff.ref_trim;
         `ADR_OSC_STATUS:   rmux[2:0] = 3'(s_ff.sw_state);
         default:           rmux = 32'h0;
      endcase
   end

   always_comb
   begin
      nxt_s = s_ff;
      nxt_s.bus_ack = (READ | WRITE) & ~s_ff.bus_ack;
      if (rd)
         nxt_s.rdata = rmux;
      if (!s_ff.boot_done)
      begin
         nxt_s.boot_done = 1'b1;
         nxt_s.current_source_sel = BOOT_SOURCE_CFG;
         nxt_s.next_source_sel = BOOT_SOURCE_CFG;
      end
      if (!switch_enabled)
         nxt_s.current_source_sel = BOOT_SOURCE_CFG;
      if (CLOCK_FAIL_EVENT)
         nxt_s.clock_fail_flag = 1'b1;
      if (PLL_LOCKED && is_pll_src)
         nxt_s.pll_lock = 1'b1;

      // Register writes and the two unlock sequences
      if (wr)
      begin
         nxt_s.unlock_high = osc_switch_pkg::UL_NONE;
         nxt_s.unlock_low = osc_switch_pkg::UL_NONE;
         unique case (ADDRESS)
            `ADR_OSC_CONTROL:
            begin
               if (BYTEENABLE[1])
               begin
                  if (s_ff.unlock_high == osc_switch_pkg::UL_OPEN)
                  begin
                     if (switch_enabled)
                        nxt_s.next_source_sel = WRITEDATA[`NXT_SRC_LSB +: 3];
                  end
                  else if (WRITEDATA[15:8] == `KEY_HIGH_A)
                     nxt_s.unlock_high = osc_switch_pkg::UL_FIRST;
                  else if (WRITEDATA[15:8] == `KEY_HIGH_B && s_ff.unlock_high == osc_switch_pkg::UL_FIRST)
                     nxt_s.unlock_high = osc_switch_pkg::UL_OPEN;
               end
               if (BYTEENABLE[0])
               begin
                  if (s_ff.unlock_low == osc_switch_pkg::UL_OPEN)
                  begin
                     if (switch_enabled && WRITEDATA[`REQ_BIT])
                        nxt_s.switch_request = 1'b1;
                  end
                  else if (WRITEDATA[7:0] == `KEY_LOW_A)
                     nxt_s.unlock_low = osc_switch_pkg::UL_FIRST;
                  else if (WRITEDATA[7:0] == `KEY_LOW_B && s_ff.unlock_low == osc_switch_pkg::UL_FIRST)
                     nxt_s.unlock_low = osc_switch_pkg::UL_OPEN;
               end
            end
            `ADR_DCO_TRIM:
               if (BYTEENABLE[0])
                  nxt_s.dco_trim_field = WRITEDATA[5:0];
            `ADR_DCO_CONTROL:
               if (BYTEENABLE[1])
               begin
                  nxt_s.dco_sleep_keep = WRITEDATA[13];
                  nxt_s.dco_freq_select = WRITEDATA[11:8];
               end
            `ADR_REF_DIVIDER:
            begin
               if (BYTEENABLE[0])
                  nxt_s.ref_div[7:0] = WRITEDATA[7:0];
               if (BYTEENABLE[1])
                  nxt_s.ref_div[14:8] = WRITEDATA[14:8];
            end
            `ADR_REF_FRACTION:
            begin
               if (BYTEENABLE[0])
                  nxt_s.ref_trim[0] = WRITEDATA[7];
               if (BYTEENABLE[1])
                  nxt_s.ref_trim[8:1] = WRITEDATA[15:8];
            end
            default:
            begin
            end
         endcase
      end

      // Switch sequencer
      unique case (s_ff.sw_state)
         osc_switch_pkg::SW_IDLE:
            if (s_ff.switch_request && switch_enabled)
            begin
               if (s_ff.next_source_sel == s_ff.current_source_sel)
                  nxt_s.switch_request = 1'b0;
               else
               begin
                  nxt_s.pll_lock = 1'b0;
                  nxt_s.clock_fail_flag = CLOCK_FAIL_EVENT;
                  nxt_s.sw_state = osc_switch_pkg::SW_START;
               end
            end
         osc_switch_pkg::SW_START:
         begin
            nxt_s.osc_on[s_ff.next_source_sel] = 1'b1;
            if (is_pll_src)
               nxt_s.osc_on[s_ff.next_source_sel - 3'h1] = 1'b1;
            nxt_s.sw_state = osc_switch_pkg::SW_WAIT_OSC;
         end
         osc_switch_pkg::SW_WAIT_OSC:
            if (OSC_READY[s_ff.next_source_sel] &&
                (!is_xtal_src || STARTUP_TIMER_DONE) &&
                (!is_pll_src || s_ff.pll_lock))
            begin
               nxt_s.settle_cnt = 4'h0;
               nxt_s.sw_state = osc_switch_pkg::SW_SETTLE;
            end
         osc_switch_pkg::SW_SETTLE:
            if (NEW_CLK_TICK)
            begin
               nxt_s.settle_cnt = s_ff.settle_cnt + 4'h1;
               if (s_ff.settle_cnt == `SETTLE_CYCLES - 4'h1)
                  nxt_s.sw_state = osc_switch_pkg::SW_HANDOVER;
            end
         osc_switch_pkg::SW_HANDOVER:
         begin
            nxt_s.current_source_sel = s_ff.next_source_sel;
            nxt_s.switch_request = 1'b0;
            nxt_s.osc_on = 7'h0;
            nxt_s.osc_on[s_ff.next_source_sel] = 1'b1;
            if (is_pll_src)
               nxt_s.osc_on[s_ff.next_source_sel - 3'h1] = 1'b1;
            nxt_s.osc_on[`SRC_LOW_POWER_RC_OSC] = nxt_s.osc_on[`SRC_LOW_POWER_RC_OSC] | WDT_OR_MONITOR_ON;
            nxt_s.osc_on[`SRC_SEC] = nxt_s.osc_on[`SRC_SEC] | SECONDARY_KEEPALIVE;
            nxt_s.sw_state = osc_switch_pkg::SW_IDLE;
         end
      endcase

      // Reference divider with fractional half-period
      if (REF_SRC_TICK && s_ff.ref_div != 15'h0)
      begin
         if (s_ff.ref_cnt + 16'h1 >= half_full + {15'h0, s_ff.ref_acc[9]})
         begin
            nxt_s.ref_cnt = 16'h0;
            nxt_s.ref_level = ~s_ff.ref_level;
            nxt_s.ref_acc = {1'b0, s_ff.ref_acc[8:0]} + {1'b0, s_ff.ref_trim};
         end
         else
            nxt_s.ref_cnt = s_ff.ref_cnt + 16'h1;
      end

      if (!NRST)
      begin
         nxt_s = '0;
         nxt_s.dco_freq_select = `DCO_FSEL_RESET;
         nxt_s.ref_div = `REF_DIV_RESET;
         nxt_s.sw_state = osc_switch_pkg::SW_IDLE;
         nxt_s.unlock_high = osc_switch_pkg::UL_NONE;
         nxt_s.unlock_low = osc_switch_pkg::UL_NONE;
         nxt_s.osc_on = 7'h7F;
      end
   end

   always_ff @(posedge CLOCK)
   begin
      s_ff <= nxt_s;
   end

   assign WAITREQUEST = (READ | WRITE) & ~s_ff.bus_ack;
   assign READDATA = s_ff.rdata;
   assign OSC_ENABLE = s_ff.osc_on;
   assign SYS_CLK_SELECT = s_ff.current_source_sel;
   assign DCO_RUN = s_ff.osc_on[`SRC_DCO] & (~SLEEP_MODE | s_ff.dco_sleep_keep);
   assign DCO_FREQ_SELECT = s_ff.dco_freq_select;
   assign DCO_TRIM_FIELD = s_ff.dco_trim_field;
   assign DCO_WIDE_STEP = (s_ff.dco_freq_select == 4'hE) | (s_ff.dco_freq_select == 4'hF);
   assign REF_CLK_OUT = (s_ff.ref_div == 15'h0) ? REF_SRC_CLK : s_ff.ref_level;

   abort_same_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_IDLE && s_ff.switch_request && switch_enabled &&
      s_ff.next_source_sel == s_ff.current_source_sel |=> !s_ff.switch_request)
      else $error("Redundant switch not aborted");
   start_clear_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_IDLE && $past(s_ff.sw_state) == osc_switch_pkg::SW_IDLE &&
      nxt_s.sw_state == osc_switch_pkg::SW_START |=> !s_ff.pll_lock)
      else $error("Lock not cleared at switch start");
   handover_copy_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_HANDOVER |=>
      s_ff.current_source_sel == $past(s_ff.next_source_sel) && !s_ff.switch_request)
      else $error("Handover did not copy source");
   settle_ten_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      $rose(s_ff.sw_state == osc_switch_pkg::SW_HANDOVER) |-> $past(s_ff.settle_cnt) == 4'h9)
      else $error("Settle count not ten");
   req_zero_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      !switch_enabled |-> !s_ff.switch_request)
      else $error("Request set while disabled");
   boot_src_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      !switch_enabled && $past(!switch_enabled) && s_ff.boot_done |-> s_ff.current_source_sel == $past(BOOT_SOURCE_CFG))
      else $error("Current source not boot source");
   ref_bypass_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.ref_div == 15'h0 |-> REF_CLK_OUT == REF_SRC_CLK)
      else $error("Reference not bypassed");
   dco_sleep_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      SLEEP_MODE && !s_ff.dco_sleep_keep |-> !DCO_RUN)
      else $error("DIGITAL_TUNED_OSC runs in sleep");
   unlock_expire_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      wr && s_ff.unlock_high == osc_switch_pkg::UL_OPEN |=> s_ff.unlock_high == osc_switch_pkg::UL_NONE)
      else $error("High unlock did not expire");
   keep_low_power_rc_osc_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_HANDOVER && WDT_OR_MONITOR_ON |=> s_ff.osc_on[`SRC_LOW_POWER_RC_OSC])
      else $error("LOW_POWER_RC_OSC stopped while needed");
   next_locked_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      wr && ADDRESS == `ADR_OSC_CONTROL && BYTEENABLE[1] && s_ff.boot_done &&
      s_ff.unlock_high != osc_switch_pkg::UL_OPEN |=> s_ff.next_source_sel == $past(s_ff.next_source_sel))
      else $error("Next source written while locked");
   req_locked_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      wr && ADDRESS == `ADR_OSC_CONTROL && BYTEENABLE[0] && !s_ff.switch_request &&
      s_ff.unlock_low != osc_switch_pkg::UL_OPEN |=> !s_ff.switch_request)
      else $error("Request set while locked");
   low_expire_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      wr && s_ff.unlock_low == osc_switch_pkg::UL_OPEN |=> s_ff.unlock_low == osc_switch_pkg::UL_NONE)
      else $error("Low unlock did not expire");
   fail_clear_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_START |-> s_ff.clock_fail_flag == $past(CLOCK_FAIL_EVENT))
      else $error("Clock fail not cleared at switch start");
   pll_wait_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_WAIT_OSC && is_pll_src && !s_ff.pll_lock |=>
      s_ff.sw_state == osc_switch_pkg::SW_WAIT_OSC)
      else $error("Left wait without PLL lock");
   xtal_wait_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_WAIT_OSC && is_xtal_src && !STARTUP_TIMER_DONE |=>
      s_ff.sw_state == osc_switch_pkg::SW_WAIT_OSC)
      else $error("Left wait before start-up timer");
   old_stop_a: assert property (@(posedge CLOCK) disable iff (!NRST)
      s_ff.sw_state == osc_switch_pkg::SW_HANDOVER && !is_pll_src && !WDT_OR_MONITOR_ON &&
      !SECONDARY_KEEPALIVE |=> s_ff.osc_on == 7'(7'h01 << s_ff.next_source_sel))
      else $error("Old source left running");

endmodule // osc_switch

/* File: inc/osc_switch_cfg.svh */
/*
 * Offsets, field positions, reset values and timing counts for the oscillator
 * control and clock switch block. Assumes inclusion from the package and the module.
 */
`ifndef OSC_SWITCH_CFG_SVH
`define OSC_SWITCH_CFG_SVH

// Register word offsets on the Avalon-MM bus
`define ADR_OSC_CONTROL   4'h0
`define ADR_DCO_TRIM      4'h1
`define ADR_DCO_CONTROL   4'h2
`define ADR_REF_DIVIDER   4'h3
`define ADR_REF_FRACTION  4'h4
`define ADR_OSC_STATUS    4'h5

// Unlock keys
`define KEY_HIGH_A        8'h78
`define KEY_HIGH_B        8'h9A
`define KEY_LOW_A         8'h46
`define KEY_LOW_B         8'h57

// Field positions in the oscillator control register
`define CUR_SRC_LSB       12
`define NXT_SRC_LSB       8
`define LOCK_BIT          5
`define FAIL_BIT          3
`define REQ_BIT           0

// Reset values
`define DCO_FSEL_RESET    4'h7
`define REF_DIV_RESET     15'h0001

// Source codes
`define SRC_FRC           3'h0
`define SRC_FRC_PLL       3'h1
`define SRC_PRI           3'h2
`define SRC_PRI_PLL       3'h3
`define SRC_SEC           3'h4
`define SRC_LOW_POWER_RC_OSC          3'h5
`define SRC_DCO           3'h6

// Settle count in new-clock cycles
`define SETTLE_CYCLES     4'hA

`endif

/* File: inc/osc_switch_pkg.sv */
/*
 * Types for the oscillator control and clock switch block.
 * Assumes the configuration header is on the include path.
 */
`include "osc_switch_cfg.svh"

package osc_switch_pkg;

   typedef enum logic [2:0] {
      SW_IDLE,
      SW_START,
      SW_WAIT_OSC,
      SW_SETTLE,
      SW_HANDOVER
   } sw_state_t;

   typedef enum logic [1:0] {
      UL_NONE,
      UL_FIRST,
      UL_OPEN
   } unlock_t;

   typedef struct packed {
      logic [5:0]  dco_trim_field;
      logic        dco_sleep_keep;
      logic [3:0]  dco_freq_select;
      logic [14:0] ref_div;
      logic [8:0]  ref_trim;
      logic [2:0]  current_source_sel;
      logic [2:0]  next_source_sel;
      logic        switch_request;
      logic        pll_lock;
      logic        clock_fail_flag;
      unlock_t     unlock_high;
      unlock_t     unlock_low;
      sw_state_t   sw_state;
      logic [3:0]  settle_cnt;
      logic [6:0]  osc_on;
      logic [15:0] ref_cnt;
      logic [9:0]  ref_acc;
      logic        ref_level;
      logic        bus_ack;
      logic [31:0] rdata;
      logic        boot_done;
   } osc_state_t;

endpackage

/* File: test/osc_switch_bench.sv */
/*
 * Self-checking bench for the oscillator control and clock switch block.
 * Assumes the package and configuration header on the include path; bench drives all status inputs.
 */
`timescale 1ns/1ns
`include "osc_switch_cfg.svh"

module osc_switch_bench;
   logic        CLOCK, NRST, READ, WRITE, SWITCH_MONITOR_CFG_BIT, STARTUP_TIMER_DONE, PLL_LOCKED;
   logic        NEW_CLK_TICK, CLOCK_FAIL_EVENT, SLEEP_MODE, WDT_OR_MONITOR_ON, SECONDARY_KEEPALIVE;
   logic        REF_SRC_CLK, REF_SRC_TICK, WAITREQUEST, DCO_RUN, DCO_WIDE_STEP, REF_CLK_OUT;
   logic [3:0]  ADDRESS, BYTEENABLE, DCO_FREQ_SELECT;
   logic [31:0] WRITEDATA, READDATA, q;
   logic [2:0]  BOOT_SOURCE_CFG, SYS_CLK_SELECT;
   logic [6:0]  OSC_READY, OSC_ENABLE;
   logic [5:0]  DCO_TRIM_FIELD;
   int          n_fail, tests_run, g;

   osc_switch dut_u (.CLOCK(CLOCK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
      .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
      .SWITCH_MONITOR_CFG_BIT(SWITCH_MONITOR_CFG_BIT), .BOOT_SOURCE_CFG(BOOT_SOURCE_CFG),
      .OSC_READY(OSC_READY), .STARTUP_TIMER_DONE(STARTUP_TIMER_DONE), .PLL_LOCKED(PLL_LOCKED),
      .NEW_CLK_TICK(NEW_CLK_TICK), .CLOCK_FAIL_EVENT(CLOCK_FAIL_EVENT), .SLEEP_MODE(SLEEP_MODE),
      .WDT_OR_MONITOR_ON(WDT_OR_MONITOR_ON), .SECONDARY_KEEPALIVE(SECONDARY_KEEPALIVE),
      .REF_SRC_CLK(REF_SRC_CLK), .REF_SRC_TICK(REF_SRC_TICK), .OSC_ENABLE(OSC_ENABLE),
      .SYS_CLK_SELECT(SYS_CLK_SELECT), .DCO_RUN(DCO_RUN), .DCO_FREQ_SELECT(DCO_FREQ_SELECT),
      .DCO_TRIM_FIELD(DCO_TRIM_FIELD), .DCO_WIDE_STEP(DCO_WIDE_STEP), .REF_CLK_OUT(REF_CLK_OUT));

   initial
   begin
      CLOCK = 1'b0;
      forever #25 CLOCK = ~CLOCK;
   end

   task automatic print_verdict();
      $display("mismatches %0d of %0d comparisons", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One Avalon transfer; entered and left just after a rising edge
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      ADDRESS <= a;
      WRITE <= we;
      READ <= ~we;
      WRITEDATA <= d;
      BYTEENABLE <= be;
      do
      begin
         @(posedge CLOCK);
         n++;
      end
      while (WAITREQUEST !== 1'b0 && n < 50);
      if (n >= 50)
         chk(32'h0000_0BAD, 32'h0);
      q = READDATA;
      WRITE <= 1'b0;
      READ <= 1'b0;
      @(posedge CLOCK);
   endtask

   task automatic rd(input logic [3:0] a);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(posedge CLOCK);
   endtask

   // Protected sequence: high byte unlock, next source, low byte unlock, request
   task automatic sw(input logic [2:0] src);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h7800, 4'h2);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h9A00, 4'h2);
      bus(1'b1, `ADR_OSC_CONTROL, {21'h0, src, 8'h00}, 4'h2);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h46, 4'h1);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h57, 4'h1);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h01, 4'h1);
      wait_c(3);
   endtask

   task automatic ticks(input int n);
      repeat (n)
      begin
         NEW_CLK_TICK <= 1'b1;
         @(posedge CLOCK);
         NEW_CLK_TICK <= 1'b0;
         @(posedge CLOCK);
      end
   endtask

   task automatic do_reset(input logic cfg, input logic [2:0] boot);
      NRST <= 1'b0;
      SWITCH_MONITOR_CFG_BIT <= cfg;
      BOOT_SOURCE_CFG <= boot;
      wait_c(12);
      NRST <= 1'b1;
      wait_c(3);
   endtask

   // Cycles until the reference output next changes
   task automatic ref_gap(output int c);
      logic v;
      v = REF_CLK_OUT;
      c = 0;
      do
      begin
         @(posedge CLOCK);
         c++;
      end
      while (REF_CLK_OUT === v && c < 100);
   endtask

   initial
   begin
      repeat (20000) @(posedge CLOCK);
      n_fail++;
      print_verdict();
   end

   initial
   begin
      {NRST, READ, WRITE, NEW_CLK_TICK, CLOCK_FAIL_EVENT, SLEEP_MODE, PLL_LOCKED} = '0;
      {WDT_OR_MONITOR_ON, SECONDARY_KEEPALIVE, REF_SRC_CLK, STARTUP_TIMER_DONE} = '0;
      {ADDRESS, BYTEENABLE, WRITEDATA} = '0;
      SWITCH_MONITOR_CFG_BIT = 1'b1;
      BOOT_SOURCE_CFG = 3'h2;
      OSC_READY = 7'h7F;
      REF_SRC_TICK = 1'b1;
      n_fail = 0;
      tests_run = 0;
      @(posedge CLOCK);
      // Switching disabled by strap
      do_reset(1'b1, 3'h2);
      rd(`ADR_OSC_CONTROL); chk(q[14:12], 32'h2);
      sw(`SRC_FRC);
      rd(`ADR_OSC_CONTROL); chk(q[0], 32'h0);
      chk(SYS_CLK_SELECT, 32'h2);
      // Second reset with switching enabled, boot from fast RC
      do_reset(1'b0, 3'h0);
      OSC_READY <= 7'h01;
      rd(`ADR_DCO_CONTROL); chk(q, 32'h0000_0700);
      rd(`ADR_REF_DIVIDER); chk(q, 32'h0000_0001);
      rd(4'h9); chk(q, 32'h0);
      bus(1'b1, `ADR_DCO_TRIM, 32'h20, 4'h3);
      rd(`ADR_DCO_TRIM); chk(q, 32'h20); chk(DCO_TRIM_FIELD, 32'h20);
      bus(1'b1, `ADR_DCO_TRIM, 32'h1F, 4'h3);
      chk(DCO_TRIM_FIELD, 32'h1F);
      for (g = 14; g <= 16; g++)
      begin
         bus(1'b1, `ADR_DCO_CONTROL, {20'h0, 4'(g == 16 ? 7 : g), 8'h00}, 4'h3);
         chk(DCO_FREQ_SELECT, 32'(g == 16 ? 7 : g));
         chk(DCO_WIDE_STEP, 32'(g != 16));
      end
      SLEEP_MODE <= 1'b1;
      bus(1'b1, `ADR_DCO_CONTROL, 32'h2700, 4'h3);
      chk(DCO_RUN, 32'h1);
      bus(1'b1, `ADR_DCO_CONTROL, 32'h0700, 4'h3);
      chk(DCO_RUN, 32'h0);
      SLEEP_MODE <= 1'b0;
      // Reference divider: pass-through, integer and fractional
      bus(1'b1, `ADR_REF_DIVIDER, 32'h0, 4'h3);
      REF_SRC_CLK <= 1'b1;
      @(negedge CLOCK); chk(REF_CLK_OUT, 32'h1);
      @(posedge CLOCK); REF_SRC_CLK <= 1'b0;
      @(negedge CLOCK); chk(REF_CLK_OUT, 32'h0);
      @(posedge CLOCK);
      bus(1'b1, `ADR_REF_DIVIDER, 32'h2, 4'h3);
      ref_gap(g); ref_gap(g); chk(32'(g), 32'h2);
      bus(1'b1, `ADR_REF_FRACTION, 32'h8000, 4'h3);
      rd(`ADR_REF_FRACTION); chk(q, 32'h8000);
      ref_gap(g); ref_gap(g); tests_run += 0;
      begin
         int h;
         ref_gap(h);
         chk(32'(g + h), 32'h5);
      end
      // Redundant request and broken unlock
      sw(`SRC_FRC);
      rd(`ADR_OSC_CONTROL); chk(q[0], 32'h0);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h7800, 4'h2);
      bus(1'b1, `ADR_DCO_TRIM, 32'h0, 4'h3);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h9A00, 4'h2);
      bus(1'b1, `ADR_OSC_CONTROL, 32'h0200, 4'h2);
      rd(`ADR_OSC_CONTROL); chk(q[10:8], 32'h0);
      // Switch to the crystal: waits on start-up timer, then 10 ticks
      CLOCK_FAIL_EVENT <= 1'b1;
      @(posedge CLOCK); CLOCK_FAIL_EVENT <= 1'b0;
      wait_c(2);
      rd(`ADR_OSC_CONTROL); chk(q[3], 32'h1);
      sw(`SRC_PRI);
      chk(OSC_ENABLE[2], 32'h1);
      rd(`ADR_OSC_CONTROL); chk({q[5], q[3], q[0]}, 32'h1);
      ticks(12);
      chk(SYS_CLK_SELECT, 32'h0);
      OSC_READY <= 7'h05;
      STARTUP_TIMER_DONE <= 1'b1;
      wait_c(3);
      ticks(9); wait_c(2);
      chk(SYS_CLK_SELECT, 32'h0);
      ticks(1); wait_c(4);
      chk(SYS_CLK_SELECT, 32'h2);
      rd(`ADR_OSC_CONTROL); chk({q[14:12], q[0]}, 32'h4);
      chk(OSC_ENABLE[0], 32'h0);
      // PLL source waits for lock
      sw(`SRC_PRI_PLL);
      ticks(12);
      rd(`ADR_OSC_CONTROL); chk({q[5], q[0]}, 32'h1);
      PLL_LOCKED <= 1'b1;
      OSC_READY <= 7'h0D;
      wait_c(3); ticks(10); wait_c(4);
      chk(SYS_CLK_SELECT, 32'h3);
      rd(`ADR_OSC_CONTROL); chk(q[5], 32'h1);
      // Through plain fast RC into fast RC with PLL
      OSC_READY <= 7'h1F;
      sw(`SRC_FRC); wait_c(3); ticks(10); wait_c(4);
      chk(SYS_CLK_SELECT, 32'h0);
      sw(`SRC_FRC_PLL); wait_c(3); ticks(10); wait_c(4);
      chk(SYS_CLK_SELECT, 32'h1);
      // Secondary kept alive after leaving it
      SECONDARY_KEEPALIVE <= 1'b1;
      sw(`SRC_SEC); wait_c(3); ticks(10); wait_c(4);
      sw(`SRC_FRC); wait_c(3); ticks(10); wait_c(4);
      chk(SYS_CLK_SELECT, 32'h0);
      chk(OSC_ENABLE[4], 32'h1);
      print_verdict();
   end
endmodule // osc_switch_bench
